// ---- include/pmw_pkg.sv ----
package pmw_pkg;
  // transaction status codes on the local side
  localparam logic [3:0] STAT_IDLE = 4'h0;
  localparam logic [3:0] STAT_ADDR_LOAD = 4'h1;
  localparam logic [3:0] STAT_BUS_TXN = 4'h2;
  localparam logic [3:0] STAT_BUS_TERM = 4'h3;

  localparam int DATA_W = 64;
  localparam int BE_W = 8;
  localparam int CMD_W = 4;
  localparam int LO_W = 32;
  localparam int BURST_W = 8;

  localparam logic [BURST_W-1:0] BURST_ZERO = 8'h00;
  localparam logic [BURST_W-1:0] BURST_ONE = 8'h01;
  localparam logic [BURST_W-1:0] BURST_TWO = 8'h02;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  // wait cycles spent deciding the transfer width
  localparam logic [1:0] WIDTH_WAITS = 2'h2;
  localparam logic [1:0] WAIT_LAST = 2'h1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_REQ = 4'b0001,
    ST_GRANT = 4'b0011,
    ST_LOAD = 4'b0010,
    ST_ADDR = 4'b0110,
    ST_WAIT = 4'b0111,
    ST_DATA = 4'b0101,
    ST_TURN = 4'b0100
  } pmw_core_e;

  typedef enum logic [1:0] {
    LM_IDLE = 2'b00,
    LM_REQ = 2'b01,
    LM_RUN = 2'b11
  } pmw_lm_e;
endpackage

// ---- include/pmw_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface pmw_if
  import pmw_pkg::*;
  (
  input wire logic i_clk_sys
);
  // local side, active-low controls end in n
  logic local_wide_request_n;
  logic local_grant_n;
  logic [3:0] local_txn_status;
  logic [DATA_W-1:0] local_ad_in;
  logic [BE_W-1:0] local_byte_enables_n;
  logic [CMD_W-1:0] local_cmd;
  logic [BURST_W-1:0] requested_burst_length;
  logic [BURST_W-1:0] remaining_burst_count;
  logic local_ready_n;
  logic low_word_taken_n;
  logic high_word_taken_n;
  logic wide_transfer_flag_n;

  modport core (
    input local_wide_request_n, local_ad_in, local_byte_enables_n, local_cmd,
    input requested_burst_length, local_ready_n,
    output local_grant_n, local_txn_status, remaining_burst_count,
    output low_word_taken_n, high_word_taken_n, wide_transfer_flag_n
  );
  modport lmaster (
    output local_wide_request_n, local_ad_in, local_byte_enables_n, local_cmd,
    output requested_burst_length, local_ready_n,
    input local_grant_n, local_txn_status, remaining_burst_count,
    input low_word_taken_n, high_word_taken_n, wide_transfer_flag_n
  );
endinterface
`default_nettype wire

// ---- rtl/pmw_word_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmw_word_src
  import pmw_pkg::*;
  (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // control
  input wire logic i_load,
  input wire logic [DATA_W-1:0] i_start,
  input wire logic i_advance,
  // word out
  output logic [DATA_W-1:0] o_word
);
  // address counter doubling as data pattern source
  logic [DATA_W-1:0] word_q;
  logic [DATA_W-1:0] word_d;

  always_comb begin
    word_d = word_q;
    if (i_load) begin
      word_d = i_start;
    end else if (i_advance) begin
      word_d = word_q + 64'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      word_q <= '0;
    end else begin
      word_q <= word_d;
    end
  end

  assign o_word = word_q;
endmodule
`default_nettype wire

// ---- rtl/pmw_local_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmw_local_master
  import pmw_pkg::*;
  (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // user request
  input wire logic i_start,
  input wire logic [DATA_W-1:0] i_addr,
  input wire logic [BURST_W-1:0] i_len,
  input wire logic i_data_ok,
  // user status
  output logic o_busy,
  output logic o_wide,
  // core side
  pmw_if.lmaster lm
);
  pmw_lm_e st_q, st_d;
  logic req_n_q, req_n_d;
  logic rdy_n_q, rdy_n_d;
  logic [DATA_W-1:0] addr_q, addr_d;
  logic [BURST_W-1:0] len_q, len_d;
  logic [BURST_W-1:0] left_q, left_d;
  logic busy_q, busy_d;
  logic wide_q, wide_d;
  logic taken;
  logic [DATA_W-1:0] word;

  assign taken = !lm.low_word_taken_n && !lm.high_word_taken_n;

  always_comb begin
    st_d = st_q;
    req_n_d = req_n_q;
    rdy_n_d = rdy_n_q;
    addr_d = addr_q;
    len_d = len_q;
    left_d = left_q;
    busy_d = busy_q;
    wide_d = !lm.wide_transfer_flag_n;
    case (st_q)
      LM_IDLE: begin
        rdy_n_d = 1'b1;
        if (i_start && i_len != BURST_ZERO) begin
          st_d = LM_REQ;
          req_n_d = 1'b0;
          addr_d = i_addr;
          len_d = i_len;
          left_d = i_len;
          busy_d = 1'b1;
        end
      end
      LM_REQ: begin
        // ready early so the first word goes with the address phase
        rdy_n_d = !i_data_ok;
        if (lm.local_txn_status == STAT_ADDR_LOAD) begin
          req_n_d = 1'b1;
          st_d = LM_RUN;
        end
      end
      LM_RUN: begin
        if (taken) begin
          left_d = left_q - BURST_ONE;
        end
        // ready only while data remains
        rdy_n_d = !(i_data_ok && left_d != BURST_ZERO);
        if (left_d == BURST_ZERO && lm.local_txn_status == STAT_BUS_TERM) begin
          st_d = LM_IDLE;
          busy_d = 1'b0;
        end
      end
      default: begin
        st_d = LM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= LM_IDLE;
      req_n_q <= 1'b1;
      rdy_n_q <= 1'b1;
      addr_q <= '0;
      len_q <= '0;
      left_q <= '0;
      busy_q <= 1'b0;
      wide_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_n_q <= req_n_d;
      rdy_n_q <= rdy_n_d;
      addr_q <= addr_d;
      len_q <= len_d;
      left_q <= left_d;
      busy_q <= busy_d;
      wide_q <= wide_d;
    end
  end

  // word held until taken, advanced after both strobes
  pmw_word_src pmw_word_src_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_load(st_q == LM_IDLE),
    .i_start(i_addr),
    .i_advance(taken),
    .o_word(word)
  );

  assign lm.local_wide_request_n = req_n_q;
  assign lm.local_ready_n = rdy_n_q;
  assign lm.local_ad_in = (st_q == LM_RUN) ? word : addr_q;
  assign lm.local_byte_enables_n = '0;
  assign lm.local_cmd = CMD_MEM_WRITE;
  assign lm.requested_burst_length = len_q;
  assign o_busy = busy_q;
  assign o_wide = wide_q;
endmodule
`default_nettype wire

// ---- rtl/pmw_core.sv ----
// Behaviour
// - local master drops request after Address Loading
// - grant plus Address Loading starts address phase
// - status becomes Bus Transaction with frame
// - burst counter loads length in address phase
// - ready gives first word, both strobes asserted
// - local ready only when data available
// - drop reqn after frame without request
// - fast target asserts devsel, ack64, trdy together
// - first word driven on ad and cben
// - first data phase: irdy high, strobes high
// - second wait cycle settles width likewise
// - untaken word stays on local bus
// - wide flag asserted, local grant follows gntn
// - local ready held through wait cycles
// - irdy deasserted means phase incomplete
// - request and grant give Address Loading
// - request lowers reqn, grant plus idle grants
`timescale 1ns/100ps
`default_nettype none
module pmw_core
  import pmw_pkg::*;
  (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // pci arbitration
  input wire logic i_gnt_n,
  output logic o_req_n,
  // pci control, output enable low while driving
  input wire logic i_frame_n,
  input wire logic i_irdy_n,
  output logic o_frame_n,
  output logic o_frame_oe_n,
  output logic o_req64_n,
  output logic o_req64_oe_n,
  output logic o_irdy_n,
  output logic o_irdy_oe_n,
  // pci target response
  input wire logic i_devsel_n,
  input wire logic i_ack64_n,
  input wire logic i_trdy_n,
  // pci address and data
  output logic [DATA_W-1:0] o_ad,
  output logic o_ad_oe_n,
  output logic [BE_W-1:0] o_cbe_n,
  output logic o_cbe_oe_n,
  // user-side status
  output logic o_phase_done,
  // local side
  pmw_if.core lm
);
  pmw_core_e st_q, st_d;
  logic req_n_q, req_n_d;
  logic frame_n_q, frame_n_d;
  logic req64_n_q, req64_n_d;
  logic irdy_n_q, irdy_n_d;
  logic oe_n_q, oe_n_d;
  logic irdy_oe_n_q, irdy_oe_n_d;
  logic [DATA_W-1:0] ad_q, ad_d;
  logic [BE_W-1:0] cbe_q, cbe_d;
  logic [3:0] stat_q, stat_d;
  logic gnt_n_q, gnt_n_d;
  logic [BURST_W-1:0] cnt_q, cnt_d;
  logic [BURST_W-1:0] len_q, len_d;
  logic [DATA_W-1:0] addr_q, addr_d;
  logic [CMD_W-1:0] cmd_q, cmd_d;
  logic xfer_n_q, xfer_n_d;
  logic wide_n_q, wide_n_d;
  logic [1:0] wait_q, wait_d;
  logic done_q, done_d;
  logic full_q, full_d;
  logic bus_idle;
  logic phase_ok;

  // bus idle when nobody frames or signals irdy
  assign bus_idle = i_frame_n && i_irdy_n;
  // a data phase completes only with irdy and trdy both low
  assign phase_ok = !irdy_n_q && !i_trdy_n;

  always_comb begin
    st_d = st_q;
    req_n_d = req_n_q;
    frame_n_d = frame_n_q;
    req64_n_d = req64_n_q;
    irdy_n_d = irdy_n_q;
    oe_n_d = oe_n_q;
    irdy_oe_n_d = irdy_oe_n_q;
    ad_d = ad_q;
    cbe_d = cbe_q;
    stat_d = stat_q;
    gnt_n_d = gnt_n_q;
    cnt_d = cnt_q;
    len_d = len_q;
    addr_d = addr_q;
    cmd_d = cmd_q;
    xfer_n_d = 1'b1;
    wide_n_d = wide_n_q;
    wait_d = wait_q;
    done_d = 1'b0;
    full_d = full_q;
    // frame seen last cycle with request already dropped
    if (!frame_n_q && lm.local_wide_request_n) begin
      req_n_d = 1'b1;
    end
    case (st_q)
      ST_IDLE: begin
        stat_d = STAT_IDLE;
        if (!lm.local_wide_request_n) begin
          req_n_d = 1'b0;
          st_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!i_gnt_n && bus_idle) begin
          gnt_n_d = 1'b0;
          st_d = ST_GRANT;
        end
      end
      ST_GRANT: begin
        stat_d = STAT_ADDR_LOAD;
        addr_d = lm.local_ad_in;
        cmd_d = lm.local_cmd;
        len_d = lm.requested_burst_length;
        st_d = ST_LOAD;
      end
      ST_LOAD: begin
        if (!i_gnt_n) begin
          frame_n_d = 1'b0;
          req64_n_d = 1'b0;
          oe_n_d = 1'b0;
          ad_d = {{(DATA_W-LO_W){1'b0}}, addr_q[LO_W-1:0]};
          cbe_d = {{(BE_W-CMD_W){1'b0}}, cmd_q};
          stat_d = STAT_BUS_TXN;
          cnt_d = len_q;
          xfer_n_d = lm.local_ready_n;
          st_d = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // first word read under the address-phase strobes
        ad_d = lm.local_ad_in;
        cbe_d = lm.local_byte_enables_n;
        full_d = !xfer_n_q;
        irdy_n_d = 1'b1;
        irdy_oe_n_d = 1'b0;
        wait_d = WIDTH_WAITS;
        st_d = ST_WAIT;
      end
      ST_WAIT: begin
        wait_d = wait_q - WAIT_LAST;
        if (wait_q == WAIT_LAST) begin
          // 64-bit only when the target claimed with ack64
          wide_n_d = i_ack64_n || i_devsel_n;
          gnt_n_d = i_gnt_n;
          st_d = ST_DATA;
        end
      end
      ST_DATA: begin
        gnt_n_d = i_gnt_n;
        if (phase_ok) begin
          done_d = 1'b1;
          cnt_d = cnt_q - BURST_ONE;
          if (cnt_q == BURST_ONE) begin
            st_d = ST_TURN;
          end
        end
        // word read under the strobes replaces the bus word
        if (!xfer_n_q) begin
          ad_d = lm.local_ad_in;
          cbe_d = lm.local_byte_enables_n;
        end
        full_d = !xfer_n_q || (full_q && !phase_ok);
        irdy_n_d = !full_d;
        // strobe only while words remain; assumes trdy stays low once given
        xfer_n_d = !(!lm.local_ready_n && cnt_d > {{(BURST_W-1){1'b0}}, full_d}
          && (!full_d || !i_trdy_n));
        if (cnt_q == BURST_ONE || (cnt_q == BURST_TWO && phase_ok)) begin
          frame_n_d = 1'b1;
          req64_n_d = 1'b1;
        end
      end
      ST_TURN: begin
        oe_n_d = 1'b1;
        irdy_oe_n_d = 1'b1;
        frame_n_d = 1'b1;
        req64_n_d = 1'b1;
        irdy_n_d = 1'b1;
        req_n_d = 1'b1;
        gnt_n_d = 1'b1;
        wide_n_d = 1'b1;
        stat_d = STAT_BUS_TERM;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= ST_IDLE;
      req_n_q <= 1'b1;
      frame_n_q <= 1'b1;
      req64_n_q <= 1'b1;
      irdy_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      irdy_oe_n_q <= 1'b1;
      ad_q <= '0;
      cbe_q <= '0;
      stat_q <= STAT_IDLE;
      gnt_n_q <= 1'b1;
      cnt_q <= '0;
      len_q <= '0;
      addr_q <= '0;
      cmd_q <= '0;
      xfer_n_q <= 1'b1;
      wide_n_q <= 1'b1;
      wait_q <= '0;
      done_q <= 1'b0;
      full_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_n_q <= req_n_d;
      frame_n_q <= frame_n_d;
      req64_n_q <= req64_n_d;
      irdy_n_q <= irdy_n_d;
      oe_n_q <= oe_n_d;
      irdy_oe_n_q <= irdy_oe_n_d;
      ad_q <= ad_d;
      cbe_q <= cbe_d;
      stat_q <= stat_d;
      gnt_n_q <= gnt_n_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      addr_q <= addr_d;
      cmd_q <= cmd_d;
      xfer_n_q <= xfer_n_d;
      wide_n_q <= wide_n_d;
      wait_q <= wait_d;
      done_q <= done_d;
      full_q <= full_d;
    end
  end

  assign o_req_n = req_n_q;
  assign o_frame_n = frame_n_q;
  assign o_frame_oe_n = oe_n_q;
  assign o_req64_n = req64_n_q;
  assign o_req64_oe_n = oe_n_q;
  assign o_irdy_n = irdy_n_q;
  assign o_irdy_oe_n = irdy_oe_n_q;
  assign o_ad = ad_q;
  assign o_ad_oe_n = oe_n_q;
  assign o_cbe_n = cbe_q;
  assign o_cbe_oe_n = oe_n_q;
  assign o_phase_done = done_q;
  assign lm.local_grant_n = gnt_n_q;
  assign lm.local_txn_status = stat_q;
  assign lm.remaining_burst_count = cnt_q;
  assign lm.low_word_taken_n = xfer_n_q;
  assign lm.high_word_taken_n = xfer_n_q;
  assign lm.wide_transfer_flag_n = wide_n_q;
endmodule
`default_nettype wire

// ---- verif/pmw_burst_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmw_burst_checker
  import pmw_pkg::*;
  (
  // clock, reset, arbitration
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_gnt_n,
  // local side
  input wire logic local_wide_request_n,
  input wire logic local_grant_n,
  input wire logic [3:0] local_txn_status,
  input wire logic [DATA_W-1:0] local_ad_in,
  input wire logic local_ready_n,
  input wire logic [BURST_W-1:0] requested_burst_length,
  input wire logic [BURST_W-1:0] remaining_burst_count,
  input wire logic low_word_taken_n,
  input wire logic high_word_taken_n,
  input wire logic wide_transfer_flag_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic go;
  assign go = local_txn_status == STAT_ADDR_LOAD && !i_gnt_n;

  load_on_grant_a: assert property (local_txn_status == STAT_IDLE && !local_wide_request_n
    && !local_grant_n |=> local_txn_status == STAT_ADDR_LOAD) else $error("no address loading");
  request_drop_a: assert property (local_txn_status == STAT_ADDR_LOAD |=> local_wide_request_n)
    else $error("request kept after address loading");
  txn_start_a: assert property (go |=> local_txn_status == STAT_BUS_TXN)
    else $error("status not bus transaction");
  count_load_a: assert property (go |=> remaining_burst_count == $past(requested_burst_length))
    else $error("burst count not loaded");
  first_take_a: assert property (go |=> low_word_taken_n == $past(local_ready_n)
    && high_word_taken_n == $past(local_ready_n)) else $error("first word strobes wrong");
  wait_hold_a: assert property (go |=> ##1 (low_word_taken_n && high_word_taken_n)[*2])
    else $error("strobe during width wait");
  strobe_pair_a: assert property (low_word_taken_n == high_word_taken_n)
    else $error("strobes split");
  hold_word_a: assert property (local_txn_status == STAT_BUS_TXN && !local_ready_n
    && low_word_taken_n && high_word_taken_n ##1 local_txn_status == STAT_BUS_TXN
    |-> $stable(local_ad_in)) else $error("untaken word changed");
  wide_in_txn_a: assert property ($fell(wide_transfer_flag_n) |->
    local_txn_status == STAT_BUS_TXN) else $error("wide flag outside transaction");

  cover property (go);
  cover property ($fell(wide_transfer_flag_n));
  cover property (go && local_ready_n);
endmodule
`default_nettype wire

// ---- verif/pci_master_burst_write_start_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module pci_master_burst_write_start_tb;
  import pmw_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic gnt_n, devsel_n, ack64_n, trdy_n, start, data_ok;
  logic [DATA_W-1:0] addr, ad;
  logic [BURST_W-1:0] len;
  logic [BE_W-1:0] cbe_n;
  logic req_n, frame_n, frame_oe_n, req64_n, req64_oe_n, irdy_n, irdy_oe_n;
  logic ad_oe_n, cbe_oe_n, phase_done;
  logic busy, wide;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int dones = 0;
  // released pins float high on the pulled-up bus
  wire logic frame_w = frame_oe_n ? 1'b1 : frame_n;
  wire logic irdy_w = irdy_oe_n ? 1'b1 : irdy_n;

  pmw_if pmw_if_inst (.i_clk_sys(i_clk_sys));
  pmw_local_master pmw_local_master_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_start(start), .i_addr(addr), .i_len(len), .i_data_ok(data_ok), .o_busy(busy),
    .o_wide(wide),
    .lm(pmw_if_inst));
  pmw_core pmw_core_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_gnt_n(gnt_n),
    .o_req_n(req_n), .i_frame_n(frame_w), .i_irdy_n(irdy_w), .o_frame_n(frame_n),
    .o_frame_oe_n(frame_oe_n), .o_req64_n(req64_n), .o_req64_oe_n(req64_oe_n),
    .o_irdy_n(irdy_n), .o_irdy_oe_n(irdy_oe_n), .i_devsel_n(devsel_n), .i_ack64_n(ack64_n),
    .i_trdy_n(trdy_n), .o_ad(ad), .o_ad_oe_n(ad_oe_n), .o_cbe_n(cbe_n),
    .o_cbe_oe_n(cbe_oe_n), .o_phase_done(phase_done), .lm(pmw_if_inst));
  pmw_burst_checker pmw_burst_checker_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_gnt_n(gnt_n),
    .local_wide_request_n(pmw_if_inst.local_wide_request_n),
    .local_grant_n(pmw_if_inst.local_grant_n),
    .local_txn_status(pmw_if_inst.local_txn_status), .local_ad_in(pmw_if_inst.local_ad_in),
    .local_ready_n(pmw_if_inst.local_ready_n),
    .requested_burst_length(pmw_if_inst.requested_burst_length),
    .remaining_burst_count(pmw_if_inst.remaining_burst_count),
    .low_word_taken_n(pmw_if_inst.low_word_taken_n),
    .high_word_taken_n(pmw_if_inst.high_word_taken_n),
    .wide_transfer_flag_n(pmw_if_inst.wide_transfer_flag_n));

  always #4 i_clk_sys = ~i_clk_sys;

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cycles++;
    if (phase_done === 1'b1)
      dones++;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_reset;
    check("reqn", 1'b1, req_n);
    check("frame_oe", 1'b1, frame_oe_n);
    check("status", STAT_IDLE, pmw_if_inst.local_txn_status);
    check("grant", 1'b1, pmw_if_inst.local_grant_n);
    $display("test reset done");
  endtask

  task automatic run_burst(input logic [63:0] a, input logic [7:0] n, input logic ack,
    input logic rdy);
    int k;
    logic [63:0] w;
    addr = a;
    len = n;
    data_ok = rdy;
    start = 1'b1;
    for (k = 0; k < 20 && req_n !== 1'b0; k++) @(negedge i_clk_sys);
    start = 1'b0;
    check("reqn", 1'b0, req_n);
    check("busy", 1'b1, busy);
    gnt_n = 1'b0;
    for (k = 0; k < 20 && frame_w !== 1'b0; k++) @(negedge i_clk_sys);
    dones = 0;
    check("req64", 1'b0, req64_n);
    check("ad_lo", a[31:0], ad[31:0]);
    check("cmd", CMD_MEM_WRITE, cbe_n[3:0]);
    check("status", STAT_BUS_TXN, pmw_if_inst.local_txn_status);
    check("count", n, pmw_if_inst.remaining_burst_count);
    check("taken", !rdy, pmw_if_inst.low_word_taken_n);
    w = pmw_if_inst.local_ad_in;
    data_ok = 1'b1;
    @(negedge i_clk_sys);
    devsel_n = 1'b0;
    ack64_n = ack;
    trdy_n = 1'b0;
    gnt_n = 1'b1;
    check("reqn_off", 1'b1, req_n);
    if (rdy)
      check("ad_word", w, ad);
    check("irdy", 1'b1, irdy_w);
    check("frame", 1'b0, frame_w);
    @(negedge i_clk_sys);
    check("irdy2", 1'b1, irdy_w);
    check("frame2", 1'b0, frame_w);
    check("no_phase", 0, dones);
    @(negedge i_clk_sys);
    check("wide", ack, pmw_if_inst.wide_transfer_flag_n);
    check("grant_follow", 1'b1, pmw_if_inst.local_grant_n);
    @(negedge i_clk_sys);
    check("wide_user", !ack, wide);
    for (k = 0; k < 80 && pmw_if_inst.local_txn_status !== STAT_IDLE; k++)
      @(negedge i_clk_sys);
    check("idle", STAT_IDLE, pmw_if_inst.local_txn_status);
    check("busy_end", 1'b0, busy);
    if (!ack)
      check("phases", n, dones);
    devsel_n = 1'b1;
    ack64_n = 1'b1;
    trdy_n = 1'b1;
    @(negedge i_clk_sys);
    $display("test burst len %0d done", n);
  endtask

  initial begin
    gnt_n = 1'b1;
    devsel_n = 1'b1;
    ack64_n = 1'b1;
    trdy_n = 1'b1;
    start = 1'b0;
    data_ok = 1'b0;
    addr = 64'h0;
    len = 8'h00;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    @(negedge i_clk_sys);
    test_reset();
    run_burst(64'h0000_0000_1234_5678, 8'h04, 1'b0, 1'b1);
    run_burst(64'h0000_0000_00ab_cd00, 8'h01, 1'b1, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
